// ===== inc/acc_pkg.sv
// Package for the converter control block: register map, fields, constants
package acc_pkg;
	localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'hF2;
	localparam logic [7:0] ADDR_CONTROL = 8'hF3;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'hF4;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'hF5;
	localparam logic [7:0] ADDR_CHANNEL_CONFIG = 8'hF6;

	localparam int BIT_QUIET_IDLE = 6;
	localparam int BIT_ENABLE = 5;
	localparam int BIT_DONE = 4;
	localparam int BIT_START = 3;
	localparam int CHAN_LSB = 0;
	localparam int CHAN_W = 3;
	localparam int DIV_W = 5;

	localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_RESULT = 8'h00;
	localparam logic [7:0] RST_CHANNEL_CONFIG = 8'h00;
	localparam logic [7:0] DIV_MASK = 8'h1F;
	localparam logic [7:0] LOW_MASK = 8'h03;

	// Conversion: one sample period plus ten bit periods
	localparam logic [3:0] CONV_PERIODS = 4'hB;
	localparam logic [3:0] SAMPLE_PERIODS = 4'h1;
	// Converter clock period is 2*(divide+1) cpu clocks
	localparam int PRESCALE_MULT = 2;

	// Interrupt vector and polling rank, informational for the controller
	localparam logic [15:0] IRQ_VECTOR = 16'h0043;
	localparam int IRQ_POLL_RANK = 9;

	typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_DECIDE} acc_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acc_sfr_req_s;
endpackage

// ===== rtl/acc_prescaler.sv
// Converter clock tick generator from the cpu clock
module acc_prescaler #(
	parameter int DIV_W = acc_pkg::DIV_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [DIV_W-1:0] divide,
	output logic tick
);
	// Count 2*(divide+1) cycles per tick; two bits wider than divide
	logic [DIV_W+1:0] count_ff;
	logic [DIV_W+1:0] limit;

	always_comb begin
		limit = (DIV_W+2)'(acc_pkg::PRESCALE_MULT) * ({2'b00, divide} + (DIV_W+2)'(1)) - (DIV_W+2)'(1);
	end

	always_ff @(posedge clk) begin
		if (reset || !run) begin
			count_ff <= '0;
		end else if (count_ff >= limit) begin
			count_ff <= '0;
		end else begin
			count_ff <= count_ff + (DIV_W+2)'(1);
		end
	end

	assign tick = run && (count_ff >= limit);
endmodule

// ===== rtl/acc_conv_ctrl.sv
// Successive conversion control: special-function registers and sequencing
module acc_conv_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire acc_pkg::acc_sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic converter_irq_enable,
	input wire logic comparator_in,
	output logic [7:0] analog_pin_config,
	output logic [2:0] analog_pin_select_bits,
	output logic converter_power,
	output logic sample_hold,
	output logic [9:0] trial_code,
	output logic cpu_idle_request,
	output logic converter_irq
);
	logic [7:0] pin_cfg_ff;
	logic [acc_pkg::DIV_W-1:0] divide_ff;
	logic quiet_idle_ff;
	logic enable_ff;
	logic done_ff;
	logic busy_ff;
	logic [acc_pkg::CHAN_W-1:0] chan_ff;
	logic [9:0] res_ff;
	logic [9:0] sar_ff;
	logic [3:0] period_ff;
	logic cmp_meta_ff;
	logic cmp_ff;
	acc_pkg::acc_state_e state_ff;
	logic tick;
	logic ctrl_wr;
	logic start_ok;
	logic finish;
	logic [9:0] bit_mask;
	logic [3:0] ticks_seen_ff;

	assign ctrl_wr = sfr_req.wr && (sfr_req.addr == acc_pkg::ADDR_CONTROL);
	assign start_ok = ctrl_wr && sfr_req.wdata[acc_pkg::BIT_START] && sfr_req.wdata[acc_pkg::BIT_ENABLE]
		&& pin_cfg_ff[sfr_req.wdata[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W]] && !busy_ff;
	assign finish = (state_ff == acc_pkg::ACC_DECIDE) && tick && (period_ff == acc_pkg::CONV_PERIODS);

	acc_prescaler #(.DIV_W(acc_pkg::DIV_W)) u_prescaler (
		.clk(clk),
		.reset(reset),
		.run(busy_ff),
		.divide(divide_ff),
		.tick(tick)
	);

	// Comparator decision is asynchronous to the sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			cmp_meta_ff <= 1'b0;
			cmp_ff <= 1'b0;
		end else begin
			cmp_meta_ff <= comparator_in;
			cmp_ff <= cmp_meta_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_cfg_ff <= acc_pkg::RST_CHANNEL_CONFIG;
			divide_ff <= acc_pkg::RST_CLOCK_DIVIDER[acc_pkg::DIV_W-1:0];
		end else if (sfr_req.wr) begin
			if (sfr_req.addr == acc_pkg::ADDR_CHANNEL_CONFIG) begin
				pin_cfg_ff <= sfr_req.wdata;
			end
			if (sfr_req.addr == acc_pkg::ADDR_CLOCK_DIVIDER) begin
				divide_ff <= sfr_req.wdata[acc_pkg::DIV_W-1:0];
			end
		end
	end

	// Configuration bits of the control register; frozen mid-conversion
	always_ff @(posedge clk) begin
		if (reset) begin
			quiet_idle_ff <= acc_pkg::RST_CONTROL[acc_pkg::BIT_QUIET_IDLE];
			enable_ff <= acc_pkg::RST_CONTROL[acc_pkg::BIT_ENABLE];
			chan_ff <= acc_pkg::RST_CONTROL[acc_pkg::CHAN_W-1:0];
		end else if (ctrl_wr && !busy_ff) begin
			quiet_idle_ff <= sfr_req.wdata[acc_pkg::BIT_QUIET_IDLE];
			enable_ff <= sfr_req.wdata[acc_pkg::BIT_ENABLE];
			chan_ff <= sfr_req.wdata[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W];
		end
	end

	// Done flag: hardware set wins over a software clear
	always_ff @(posedge clk) begin
		if (reset) begin
			done_ff <= acc_pkg::RST_CONTROL[acc_pkg::BIT_DONE];
		end else if (finish) begin
			done_ff <= 1'b1;
		end else if (ctrl_wr && !sfr_req.wdata[acc_pkg::BIT_DONE]) begin
			done_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= acc_pkg::ACC_IDLE;
			busy_ff <= 1'b0;
			period_ff <= '0;
			sar_ff <= '0;
		end else begin
			unique case (state_ff)
				acc_pkg::ACC_IDLE: begin
					if (start_ok) begin
						state_ff <= acc_pkg::ACC_SAMPLE;
						busy_ff <= 1'b1;
						period_ff <= '0;
						sar_ff <= 10'h200;
					end
				end
				acc_pkg::ACC_SAMPLE: begin
					if (tick) begin
						state_ff <= acc_pkg::ACC_DECIDE;
						period_ff <= acc_pkg::SAMPLE_PERIODS + 4'h1;
					end
				end
				acc_pkg::ACC_DECIDE: begin
					if (tick) begin
						// Keep trial bit if input is above trial level, then try next bit
						sar_ff <= (cmp_ff ? sar_ff : (sar_ff & ~bit_mask)) | (bit_mask >> 1);
						period_ff <= period_ff + 4'h1;
						if (finish) begin
							state_ff <= acc_pkg::ACC_IDLE;
							busy_ff <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_comb begin
		bit_mask = 10'h200 >> (period_ff - acc_pkg::SAMPLE_PERIODS - 4'h1);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			res_ff <= {acc_pkg::RST_RESULT, acc_pkg::RST_RESULT[1:0]};
		end else if (finish) begin
			res_ff <= cmp_ff ? sar_ff : (sar_ff & ~bit_mask);
		end
	end

	// Read mux; reserved bits read zero
	always_comb begin
		sfr_rdata = 8'h00;
		unique case (sfr_req.addr)
			acc_pkg::ADDR_CLOCK_DIVIDER: sfr_rdata = {3'b000, divide_ff} & acc_pkg::DIV_MASK;
			acc_pkg::ADDR_CONTROL: sfr_rdata = {1'b0, quiet_idle_ff, enable_ff, done_ff, busy_ff, chan_ff};
			acc_pkg::ADDR_RESULT_LOW: sfr_rdata = {6'b000000, res_ff[1:0]} & acc_pkg::LOW_MASK;
			acc_pkg::ADDR_RESULT_HIGH: sfr_rdata = res_ff[9:2];
			acc_pkg::ADDR_CHANNEL_CONFIG: sfr_rdata = pin_cfg_ff;
			default: sfr_rdata = 8'h00;
		endcase
	end

	assign analog_pin_config = pin_cfg_ff;
	assign analog_pin_select_bits = chan_ff;
	assign converter_power = enable_ff;
	assign sample_hold = (state_ff == acc_pkg::ACC_SAMPLE);
	assign trial_code = sar_ff;
	assign cpu_idle_request = busy_ff && quiet_idle_ff;
	// Global enable is applied by the interrupt controller
	assign converter_irq = done_ff && converter_irq_enable;

	// Tick count kept apart from period_ff so the length check is not circular
	always_ff @(posedge clk) begin
		if (reset || start_ok) begin
			ticks_seen_ff <= '0;
		end else if (busy_ff && tick) begin
			ticks_seen_ff <= ticks_seen_ff + 4'h1;
		end
	end

	a_start_sets_busy: assert property (@(posedge clk) disable iff (reset) start_ok |=> busy_ff)
		else $error("start did not set busy");
	a_no_start_digital: assert property (@(posedge clk) disable iff (reset)
		(ctrl_wr && !pin_cfg_ff[sfr_req.wdata[2:0]] && !busy_ff) |=> !busy_ff)
		else $error("start on digital pin ran");
	a_standby_idle: assert property (@(posedge clk) disable iff (reset) !enable_ff |-> !busy_ff)
		else $error("conversion in standby");
	a_done_with_result: assert property (@(posedge clk) disable iff (reset) finish |=> (done_ff && !busy_ff))
		else $error("done flag not set at finish");
	a_result_stable: assert property (@(posedge clk) disable iff (reset) !finish |=> $stable(res_ff))
		else $error("result changed without finish");
	a_idle_request: assert property (@(posedge clk) disable iff (reset)
		(cpu_idle_request && !finish) |=> cpu_idle_request)
		else $error("cpu idle dropped mid conversion");
	a_idle_on_start: assert property (@(posedge clk) disable iff (reset)
		(start_ok && sfr_req.wdata[acc_pkg::BIT_QUIET_IDLE]) |=> cpu_idle_request)
		else $error("quiet conversion did not idle cpu");
	a_done_sticky: assert property (@(posedge clk) disable iff (reset)
		(done_ff && !ctrl_wr) |=> done_ff)
		else $error("done flag cleared by hardware");
	a_irq_gate: assert property (@(posedge clk) disable iff (reset)
		(finish && converter_irq_enable) ##1 converter_irq_enable |-> converter_irq)
		else $error("no interrupt after enabled finish");
	a_eleven_periods: assert property (@(posedge clk) disable iff (reset)
		(busy_ff && tick) |-> (finish == (ticks_seen_ff == acc_pkg::CONV_PERIODS - 4'h1)))
		else $error("conversion length wrong");
endmodule

// ===== bench/acc_front_model.sv
// Analog front end model: one fixed level per channel, ideal comparator
module acc_front_model (
	input wire logic [9:0] trial_code,
	input wire logic [2:0] sel,
	input wire logic power,
	output logic comparator_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] level;
	// Level differs per channel so a wrong select shows in the result
	assign level = {sel, 7'h55};
	// Standby front end gives no decisions
	assign comparator_in = power & (level >= trial_code);
endmodule

// ===== bench/test_adc_conversion_control.sv
// Self-checking bench for the converter control block
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("BAD %0t got %h want %h", $time, a, b); end end
module test_adc_conversion_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic irq_en = 1'b0;
	acc_pkg::acc_sfr_req_s req = '0;
	logic [7:0] rdata, d, cw, pcfg;
	logic [2:0] sel, c;
	logic [9:0] trial, lvl;
	logic pwr, sh, idle, irq, cmp;
	int fails = 0;
	int tests_run = 0;
	int n;
	always #5 clk = ~clk;
	acc_conv_ctrl dut (.clk(clk), .reset(reset), .sfr_req(req), .sfr_rdata(rdata), .converter_irq_enable(irq_en),
		.comparator_in(cmp), .analog_pin_config(pcfg), .analog_pin_select_bits(sel), .converter_power(pwr),
		.sample_hold(sh), .trial_code(trial), .cpu_idle_request(idle), .converter_irq(irq));
	acc_front_model fe (.trial_code(trial), .sel(sel), .power(pwr), .comparator_in(cmp));
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		req.addr = a;
		req.wdata = v;
		req.wr = 1'b1;
		@(negedge clk);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		req.addr = a;
		#1 d = rdata;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		`CHK(d, e)
	endtask
	task automatic summarize;
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#50us;
		fails++;
		summarize;
	end
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		for (int a = 8'hF2; a <= 8'hF7; a++) begin
			chk_rd(8'(a), 8'h00);
		end
		$display("reset values done");
		wr(acc_pkg::ADDR_CLOCK_DIVIDER, 8'h15);
		chk_rd(acc_pkg::ADDR_CLOCK_DIVIDER, 8'h15);
		// Divide 1 keeps ticks apart enough for the comparator sync
		wr(acc_pkg::ADDR_CLOCK_DIVIDER, 8'h01);
		wr(acc_pkg::ADDR_CHANNEL_CONFIG, 8'hFE);
		chk_rd(acc_pkg::ADDR_CHANNEL_CONFIG, 8'hFE);
		`CHK(pcfg, 8'hFE)
		wr(acc_pkg::ADDR_CONTROL, 8'h0D);
		chk_rd(acc_pkg::ADDR_CONTROL, 8'h05);
		`CHK(pwr, 1'b0)
		wr(acc_pkg::ADDR_CONTROL, 8'h20);
		#4us;
		`CHK(pwr, 1'b1)
		wr(acc_pkg::ADDR_CONTROL, 8'h28);
		chk_rd(acc_pkg::ADDR_CONTROL, 8'h20);
		$display("refused starts done");
		for (int ch = 1; ch < 8; ch++) begin
			c = 3'(ch);
			@(negedge clk) irq_en = c[1];
			cw = 8'h28 | {5'h00, c} | (c[0] ? 8'h40 : 8'h00);
			if (c[0]) begin
				rd(acc_pkg::ADDR_CONTROL);
				wr(acc_pkg::ADDR_CONTROL, d & 8'hF8);
				wr(acc_pkg::ADDR_CONTROL, (d & 8'hF8) | {5'h00, c});
			end
			wr(acc_pkg::ADDR_CONTROL, cw);
			`CHK(idle, c[0])
			`CHK(sh, 1'b1)
			`CHK(trial, 10'h200)
			`CHK(sel, c)
			chk_rd(acc_pkg::ADDR_CONTROL, cw);
			wr(acc_pkg::ADDR_RESULT_HIGH, 8'hAA);
			n = 0;
			do begin
				rd(acc_pkg::ADDR_CONTROL);
				n++;
			end while (d[3] === 1'b1 && n < 200);
			// Polling adds a few cycles around the eleven ticks of four cycles
			`CHK(n inside {[36:48]}, 1'b1)
			`CHK(d, cw ^ 8'h18)
			`CHK(irq, c[1])
			`CHK(idle, 1'b0)
			`CHK(sh, 1'b0)
			lvl = {c, 7'h55};
			chk_rd(acc_pkg::ADDR_RESULT_HIGH, lvl[9:2]);
			chk_rd(acc_pkg::ADDR_RESULT_LOW, {6'h00, lvl[1:0]});
			wr(acc_pkg::ADDR_CONTROL, 8'h20 | {5'h00, c});
			chk_rd(acc_pkg::ADDR_CONTROL, 8'h20 | {5'h00, c});
			`CHK(irq, 1'b0)
			$display("conversion on channel %0d done", ch);
		end
		summarize;
	end
endmodule
